//--- core/iox_core.sv
// Sixteen-bit I/O expander: serial slave, port registers, change alert, APB.
`include "iox_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module iox_core (
   // Clock and reset.
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave.
   input  wire logic [11:0]       paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Serial link, open drain.
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe,
   // Port pins and straps.
   input  wire iox_pkg::iox_port_t gpio_i,
   output iox_pkg::iox_port_t     gpio_o,
   output iox_pkg::iox_port_t     gpio_oe,
   input  wire logic              rst_pin_n,
   input  wire logic              addr_sel,
   // Change alert, open drain, and interrupt.
   output logic                   alert_o,
   output logic                   alert_oe,
   output logic                   irq
);
   import iox_pkg::*;

   // ==========================================================================
   // Input synchronisers
   logic [19:0] meta;
   logic [19:0] sync;
   logic        scl_d;
   logic        sda_d;
   logic        scl_s;
   logic        sda_s;
   logic        rst_s;
   logic        adr_s;
   iox_port_t   pin_s;

   // Every outside level passes two flops; only the second is read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 20'hFFFFF;
         sync <= 20'hFFFFF;
      end else begin
         meta <= {scl_i, sda_i, rst_pin_n, addr_sel, gpio_i};
         sync <= meta;
      end
   end

   assign scl_s = sync[19];
   assign sda_s = sync[18];
   assign rst_s = sync[17];
   assign adr_s = sync[16];
   assign pin_s = iox_port_t'(sync[15:0]);

   // Delayed copies for edge detection on the synchronised link.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic [6:0] slv_addr;
   // Base address held in a sized constant so that bits 6:1 of it can be selected.
   localparam logic [6:0] SLV_BASE = `IOX_SLV_BASE;

   // At 200 MHz a 400 kHz clock gives 500 samples per period, ample margin.
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start    = scl_s & scl_d & sda_d & ~sda_s;
   assign stop     = scl_s & scl_d & ~sda_d & sda_s;
   assign slv_addr = {SLV_BASE[6:1], adr_s};

   // ==========================================================================
   // Port registers
   iox_port_t out_reg;
   iox_port_t pol;
   iox_port_t cfg;
   iox_port_t in_view;
   iox_port_t snap;

   // Read value of the input register.
   assign in_view = pin_s ^ pol;

   // Picks one bank of a register.
   function automatic logic [7:0] pick(input logic b, input iox_port_t w);
      pick = b ? w.bank1 : w.bank0;
   endfunction

   // ==========================================================================
   // Serial slave
   iox_state_t st;
   iox_kind_t  kind;
   logic [3:0] bcnt;
   logic [7:0] sh;
   logic [2:0] ptr;
   logic       rw;
   logic       wr_en;
   logic       rd_load;
   logic [7:0] rd_byte;

   // Register selected by the command pointer.
   always_comb begin
      unique case (ptr[2:1])
         `IOX_CMD_IN:  rd_byte = pick(ptr[0], in_view);
         `IOX_CMD_OUT: rd_byte = pick(ptr[0], out_reg);
         `IOX_CMD_POL: rd_byte = pick(ptr[0], pol);
         `IOX_CMD_CFG: rd_byte = pick(ptr[0], cfg);
      endcase
   end

   // A data byte is written at the falling edge that ends its eighth bit.
   assign wr_en = (st == S_RX) && scl_fall && (bcnt == 4'h8) && (kind == K_DATA);
   // A byte is loaded for sending after an acknowledge.
   assign rd_load = scl_fall &&
                    (((st == S_RXACK) && (kind == K_ADDR) && rw) ||
                     (st == S_TXACK));

   // Bus state machine; stop, reset pin and power-on all return it to idle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st     <= S_IDLE;
         kind   <= K_ADDR;
         bcnt   <= 4'h0;
         sh     <= 8'h00;
         ptr    <= 3'h0;
         rw     <= 1'b0;
         sda_oe <= 1'b0;
      end else if (!rst_s || stop) begin
         st     <= S_IDLE;
         sda_oe <= 1'b0;
      end else if (start) begin
         st     <= S_RX;
         kind   <= K_ADDR;
         bcnt   <= 4'h0;
         sda_oe <= 1'b0;
      end else if (rd_load) begin
         sh     <= {rd_byte[6:0], 1'b0};
         sda_oe <= ~rd_byte[7];
         bcnt   <= 4'h1;
         ptr[0] <= ~ptr[0];
         st     <= S_TX;
      end else begin
         unique case (st)
            S_IDLE: begin
            end
            S_RX: begin
               if (scl_rise) begin
                  sh   <= {sh[6:0], sda_s};
                  bcnt <= bcnt + 4'h1;
               end else if (scl_fall && (bcnt == 4'h8)) begin
                  if ((kind == K_ADDR) && (sh[7:1] != slv_addr)) begin
                     st <= S_IDLE;
                  end else begin
                     sda_oe <= 1'b1;
                     st     <= S_RXACK;
                  end
                  if (kind == K_ADDR) begin
                     rw <= sh[0];
                  end
                  if (kind == K_CMD) begin
                     ptr <= sh[2:0];
                  end
                  if (kind == K_DATA) begin
                     ptr[0] <= ~ptr[0];
                  end
               end
            end
            S_RXACK: begin
               if (scl_fall) begin
                  sda_oe <= 1'b0;
                  bcnt   <= 4'h0;
                  st     <= S_RX;
                  kind   <= (kind == K_ADDR) ? K_CMD : K_DATA;
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  if (bcnt == 4'h8) begin
                     sda_oe <= 1'b0;
                     st     <= S_TXACK;
                  end else begin
                     sda_oe <= ~sh[7];
                     sh     <= {sh[6:0], 1'b0};
                     bcnt   <= bcnt + 4'h1;
                  end
               end
            end
            S_TXACK: begin
               // A not-acknowledge ends the read before the next falling edge.
               if (scl_rise && sda_s) begin
                  st <= S_IDLE;
               end
            end
         endcase
      end
   end

   // Open drain: the line is only ever pulled low.
   assign sda_o = 1'b0;

   // ==========================================================================
   // Register writes; the input register itself is read-only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_reg <= `IOX_OUT_RST;
         pol     <= `IOX_POL_RST;
         cfg     <= `IOX_CFG_RST;
      end else if (!rst_s) begin
         out_reg <= `IOX_OUT_RST;
         pol     <= `IOX_POL_RST;
         cfg     <= `IOX_CFG_RST;
      end else if (wr_en) begin
         unique case ({ptr[2:1], ptr[0]})
            {`IOX_CMD_OUT, 1'b0}: out_reg.bank0 <= sh;
            {`IOX_CMD_OUT, 1'b1}: out_reg.bank1 <= sh;
            {`IOX_CMD_POL, 1'b0}: pol.bank0 <= sh;
            {`IOX_CMD_POL, 1'b1}: pol.bank1 <= sh;
            {`IOX_CMD_CFG, 1'b0}: cfg.bank0 <= sh;
            {`IOX_CMD_CFG, 1'b1}: cfg.bank1 <= sh;
            default: begin
            end
         endcase
      end
   end

   // Outputs drive the latched value; the enable follows direction.
   assign gpio_o = out_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_oe <= 16'h0000;
      end else begin
         gpio_oe <= ~cfg;
      end
   end

   // ==========================================================================
   // Change detection against the stored input state.
   logic [1:0] prime_cnt;
   iox_port_t  diff;

   // The snapshot waits until the synchronisers carry real pin levels, so that
   // their reset value never counts as a change; a bank read retakes it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prime_cnt <= 2'h0;
         snap      <= 16'h0000;
      end else if (prime_cnt != 2'h3) begin
         prime_cnt <= prime_cnt + 2'h1;
         snap      <= pin_s;
      end else if (!rst_s) begin
         snap <= pin_s;
      end else if (rd_load && (ptr[2:1] == `IOX_CMD_IN)) begin
         if (ptr[0]) begin
            snap.bank1 <= pin_s.bank1;
         end else begin
            snap.bank0 <= pin_s.bank0;
         end
      end
   end

   // Only pins set as inputs can raise the alert.
   assign diff = (pin_s ^ snap) & cfg & {16{prime_cnt == 2'h3}};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alert_oe <= 1'b0;
      end else begin
         alert_oe <= |diff;
      end
   end
   assign alert_o = 1'b0;

   // ==========================================================================
   // APB slave, answering in the first access cycle.
   logic [`IOX_ST_W-1:0] stat;
   logic [`IOX_ST_W-1:0] mask;
   logic [`IOX_ST_W-1:0] ev;
   logic                 wr_acc;

   assign wr_acc = psel & penable & pready & pwrite & ~pslverr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready <= psel & ~penable;
         if (psel && !penable) begin
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            case (paddr)
               `IOX_OFF_STAT: prdata <= {29'h0, stat};
               `IOX_OFF_MASK: prdata <= {29'h0, mask};
               `IOX_OFF_PORT: prdata <= {in_view, out_reg};
               `IOX_OFF_CFG:  prdata <= {pol, cfg};
               default:       pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Mask register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= 3'h0;
      end else if (wr_acc && (paddr == `IOX_OFF_MASK)) begin
         mask <= pwdata[`IOX_ST_W-1:0];
      end
   end

   // Sticky status; a set in the cycle of a write-one clear wins.
   assign ev = {wr_en, |diff.bank1, |diff.bank0};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat <= 3'h0;
      end else if (wr_acc && (paddr == `IOX_OFF_STAT)) begin
         stat <= (stat & ~pwdata[`IOX_ST_W-1:0]) | ev;
      end else begin
         stat <= stat | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat & mask);
      end
   end

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_addr_hit;
      (st == S_RX) && (kind == K_ADDR) && scl_fall && (bcnt == 4'h8) &&
      (sh[7:1] == slv_addr) && rst_s && !stop && !start;
   endsequence

   sequence s_in_read;
      rd_load && (ptr[2:1] == `IOX_CMD_IN) && rst_s && !stop && !start;
   endsequence

   a_addr_ack: assert property (s_addr_hit |=> sda_oe && (st == S_RXACK))
      else $error("address match not acknowledged");
   a_pol_view: assert property (s_in_read |=> sh[7:1] == $past(rd_byte[6:0]))
      else $error("input byte not loaded with polarity");
   a_dir_pins: assert property (##1 gpio_oe == ~$past(cfg))
      else $error("pin enable does not follow direction");
   a_reset_pin: assert property (!rst_s |=> cfg == 16'hFFFF ##1 gpio_oe == 16'h0000)
      else $error("reset pin did not restore inputs");
   a_stop_idle: assert property (stop |=> (st == S_IDLE) && !sda_oe)
      else $error("stop did not idle the bus logic");
   a_alert_set: assert property ((|diff) |=> alert_oe)
      else $error("alert missing on input change");
   a_alert_free: assert property (!(|diff) |=> !alert_oe)
      else $error("alert held without change");
   a_out_hold: assert property (!wr_en && rst_s |=> $stable(out_reg))
      else $error("output latch moved without a write");
   a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("APB answer not in first access cycle");
endmodule
`default_nettype wire

//--- include/iox_defines.svh
// Offsets, field positions, reset values and timing counts of the I/O expander.
`ifndef IOX_DEFINES_SVH
`define IOX_DEFINES_SVH
// ==========================================================================
// APB register offsets (byte addresses).
`define IOX_OFF_STAT  12'h000
`define IOX_OFF_MASK  12'h004
`define IOX_OFF_PORT  12'h008
`define IOX_OFF_CFG   12'h00C
// ==========================================================================
// Status and mask bit positions.
`define IOX_ST_CHG0   0
`define IOX_ST_CHG1   1
`define IOX_ST_WR     2
`define IOX_ST_W      3
// ==========================================================================
// Serial command kinds, taken from command bits 2:1; bit 0 picks the bank.
`define IOX_CMD_IN    2'h0
`define IOX_CMD_OUT   2'h1
`define IOX_CMD_POL   2'h2
`define IOX_CMD_CFG   2'h3
// ==========================================================================
// Reset values; a set direction bit means input.
`define IOX_CFG_RST   16'hFFFF
`define IOX_OUT_RST   16'hFFFF
`define IOX_POL_RST   16'h0000
// Slave address with bit 0 replaced by the address-select pin.
`define IOX_SLV_BASE  7'h20
// ==========================================================================
// Timing: system clock and fastest serial clock, in hertz.
`define IOX_CLK_HZ    200000000
`define IOX_SCL_HZ    400000
`define IOX_SCL_CYC   (`IOX_CLK_HZ / `IOX_SCL_HZ)
`endif

//--- include/iox_pkg.sv
// Types shared by the I/O expander design.
package iox_pkg;
   // Sixteen pins as two 8-bit banks.
   typedef struct packed {
      logic [7:0] bank1;
      logic [7:0] bank0;
   } iox_port_t;
   // Serial slave states.
   typedef enum logic [2:0] {S_IDLE, S_RX, S_RXACK, S_TX, S_TXACK} iox_state_t;
   // Meaning of the byte being received.
   typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} iox_kind_t;
endpackage

//--- verification/iox_host.sv
// Serial bus master model that stands for the system controller on the link.
`timescale 1ns/1ps
`default_nettype none
module iox_host (
   // Open-drain link; a one on sda_pull pulls the data line low.
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   // ======================================================================
   // Link timing: a quarter of the 125 ns link period.
   localparam realtime Q = 31.25;

   // Both lines idle released, so the pull-ups hold them high between frames.
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // One bit slot: data only moves while the clock is low, sampled mid high.
   task automatic bit_io(input logic b, output logic r);
      sda_pull = !b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
      #Q;
   endtask

   // Start, also usable as a repeated start right after an acknowledge slot.
   task automatic start();
      sda_pull = 1'b0;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b0;
      #Q;
   endtask

   // Stop leaves both lines released, so the clock stands still afterwards.
   task automatic stop();
      sda_pull = 1'b1;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b0;
      #Q;
   endtask

   // Byte out, most significant bit first, then the slave's acknowledge.
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask

   // Byte in; the last byte is refused so the slave lets go of the line.
   task automatic rbyte(output logic [7:0] b, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(last, r);
   endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench of the I/O expander: APB, serial link, pins and alert.
`include "iox_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin failures++; \
   $display("BAD %s exp %h got %h", nm, e, a); end end
module testbench;
   import iox_pkg::*;
   // ======================================================================
   // Signals of the design and of the bench.
   logic        pclk, presetn, psel, penable, pwrite, rst_pin_n, addr_sel, ack;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, scl, sda_pull, sda, sda_o, sda_oe, alert_o, alert_oe, irq;
   iox_port_t   gpio_i, gpio_o, gpio_oe;
   logic [15:0] ext, oe_v, o_v, out_e, pol_e, dir_e, rd;
   logic [65:0] q[$];
   logic [65:0] note;
   int          failures, n_tests, cyc, seed;

   always #2.5 pclk = ~pclk;
   // A driven pin shows the device's level; otherwise the outside level.
   assign oe_v   = gpio_oe;
   assign o_v    = gpio_o;
   assign gpio_i = (oe_v & o_v) | (~oe_v & ext);
   // Data line with pull-up: low while either party pulls it.
   assign sda    = !(sda_pull || (sda_oe && !sda_o));

   iox_core u_iox_core (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
      .rst_pin_n(rst_pin_n), .addr_sel(addr_sel), .alert_o(alert_o),
      .alert_oe(alert_oe), .irq(irq));
   iox_host u_iox_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

   // ======================================================================
   // Closing report and hang guard.
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // The whole sequence needs about 14000 cycles; the guard leaves headroom.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         print_verdict();
      end
   end

   // ======================================================================
   // APB master; each transfer notes {pslverr, prdata} expected and a mask.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e, input logic [32:0] m);
      @(posedge pclk);
      q.push_back({e, m});
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Watcher: every completed transfer is checked against the oldest note.
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         note = q.pop_front();
         `CHK("apb", note[65:33] & note[32:0], {pslverr, prdata} & note[32:0])
      end
   end

   // ======================================================================
   // Serial transfers through the master model.
   function automatic logic [6:0] slv();
      return `IOX_SLV_BASE | {6'h00, addr_sel};
   endfunction

   function automatic logic [15:0] exp_in();
      return ((~dir_e & out_e) | (dir_e & ext)) ^ pol_e;
   endfunction

   task automatic i2c_w(input logic [6:0] a, input logic ok, input logic [7:0] c,
                        input logic [15:0] d);
      u_iox_host.start();
      u_iox_host.wbyte({a, 1'b0}, ack);
      `CHK("addr ack", ok, ack)
      if (ok) begin
         u_iox_host.wbyte(c, ack);
         u_iox_host.wbyte(d[7:0], ack);
         u_iox_host.wbyte(d[15:8], ack);
      end
      u_iox_host.stop();
   endtask

   task automatic i2c_r(input logic [7:0] c, output logic [15:0] v);
      u_iox_host.start();
      u_iox_host.wbyte({slv(), 1'b0}, ack);
      u_iox_host.wbyte(c, ack);
      u_iox_host.start();
      u_iox_host.wbyte({slv(), 1'b1}, ack);
      u_iox_host.rbyte(v[7:0], 1'b0);
      u_iox_host.rbyte(v[15:8], 1'b1);
      u_iox_host.stop();
   endtask

   task automatic settle();
      repeat (6) @(posedge pclk);
   endtask

   // ======================================================================
   // Main sequence.
   initial begin
      seed = 98;
      {pclk, presetn, psel, penable, pwrite} = '0;
      {paddr, pwdata} = '0;
      {rst_pin_n, addr_sel} = 2'b10;
      ext = 16'($random(seed));
      {failures, n_tests, cyc} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      `CHK("oe reset", 16'h0000, oe_v)
      `CHK("out reset", `IOX_OUT_RST, o_v)
      `CHK("alert idle", 1'b0, alert_oe)
      apb(0, `IOX_OFF_CFG, 0, {1'b0, `IOX_POL_RST, `IOX_CFG_RST}, '1);
      apb(0, `IOX_OFF_MASK, 0, 33'h0, '1);
      apb(0, 12'h010, 0, {1'b1, 32'h0}, '1);
      apb(1, 12'h010, 32'h5, {1'b1, 32'h0}, {1'b1, 32'h0});
      apb(1, `IOX_OFF_CFG, 32'h0, 33'h0, {1'b1, 32'h0});
      apb(0, `IOX_OFF_CFG, 0, {1'b0, `IOX_POL_RST, `IOX_CFG_RST}, '1);
      // Both address-select levels; the other address must go unanswered.
      for (int s = 0; s < 2; s++) begin
         @(posedge pclk);
         addr_sel <= s[0];
         settle();
         i2c_w(slv() ^ 7'h01, 1'b0, 8'h02, 16'h0);
         i2c_w(slv(), 1'b1, 8'h02, 16'h0);
      end
      // Every command kind; the input kind must be ignored.
      for (int k = 0; k < 4; k++) begin
         rd = 16'($random(seed));
         if (k == 3) rd[0] = 1'b1;
         i2c_w(slv(), 1'b1, {5'h00, k[1:0], 1'b0}, rd);
         case (k)
            1: out_e = rd;
            2: pol_e = rd;
            3: dir_e = rd;
            default: ;
         endcase
      end
      settle();
      `CHK("pins out", out_e, o_v)
      `CHK("pins oe", ~dir_e, oe_v)
      apb(0, `IOX_OFF_PORT, 0, {1'b0, exp_in(), out_e}, '1);
      apb(0, `IOX_OFF_CFG, 0, {1'b0, pol_e, dir_e}, '1);
      apb(0, `IOX_OFF_STAT, 0, 33'h4, 33'h4);
      apb(1, `IOX_OFF_STAT, 32'h4, 33'h0, {1'b1, 32'h0});
      apb(0, `IOX_OFF_STAT, 0, 33'h0, 33'h4);
      for (int k = 0; k < 4; k++) begin
         i2c_r({5'h00, k[1:0], 1'b0}, rd);
         `CHK("serial read", k == 0 ? exp_in() : k == 1 ? out_e : k == 2 ? pol_e : dir_e, rd)
      end
      // Change alert: masked, unmasked, pin return, then cleared by a read.
      apb(1, `IOX_OFF_MASK, 32'h0, 33'h0, {1'b1, 32'h0});
      ext <= ext ^ 16'h0001;
      settle();
      `CHK("alert set", 1'b1, alert_oe)
      `CHK("irq masked", 1'b0, irq)
      apb(1, `IOX_OFF_MASK, 32'h1, 33'h0, {1'b1, 32'h0});
      settle();
      `CHK("irq on", 1'b1, irq)
      ext <= ext ^ 16'h0001;
      settle();
      `CHK("alert return", 1'b0, alert_oe)
      ext <= ext ^ 16'h0001;
      settle();
      `CHK("alert again", 1'b1, alert_oe)
      i2c_r(8'h00, rd);
      `CHK("input read", exp_in(), rd)
      settle();
      `CHK("alert read", 1'b0, alert_oe)
      apb(1, `IOX_OFF_STAT, 32'h3, 33'h0, {1'b1, 32'h0});
      settle();
      `CHK("irq cleared", 1'b0, irq)
      // Reset pin: port registers back to defaults, status and mask kept.
      rst_pin_n <= 1'b0;
      settle();
      rst_pin_n <= 1'b1;
      settle();
      `CHK("out pin rst", `IOX_OUT_RST, o_v)
      `CHK("oe pin rst", 16'h0000, oe_v)
      apb(0, `IOX_OFF_CFG, 0, {1'b0, `IOX_POL_RST, `IOX_CFG_RST}, '1);
      apb(0, `IOX_OFF_MASK, 0, 33'h1, '1);
      i2c_w(slv(), 1'b1, 8'h02, 16'h1234);
      settle();
      `CHK("out after rst", 16'h1234, o_v)
      // A command that starts at bank 1 fills bank 1 first, then bank 0.
      i2c_w(slv(), 1'b1, 8'h03, 16'h5678);
      settle();
      `CHK("bank1 first", 16'h7856, o_v)
      print_verdict();
   end
endmodule
`default_nettype wire
